// ---- src/lsb_regs.svh ----
`ifndef LSB_REGS_SVH
`define LSB_REGS_SVH
// register byte offsets
`define LSB_OFF_TX0 8'h00
`define LSB_OFF_TX1 8'h04
`define LSB_OFF_TX2 8'h08
`define LSB_OFF_CTRL 8'h0c
`define LSB_OFF_STRW 8'h10
`define LSB_OFF_RX0 8'h14
`define LSB_OFF_RX1 8'h18
`define LSB_OFF_RX2 8'h1c
`define LSB_OFF_STAT 8'h20
`define LSB_OFF_PORT 8'h24
// transfer_control, strobe width and port fields, reset byte
`define LSB_CTL_GO 7
`define LSB_CTL_BUS 6
`define LSB_CTL_ANS 5
`define LSB_CTL_L3 3
`define LSB_CTL_L2 2
`define LSB_CTL_L1 1
`define LSB_CTL_L0 0
`define LSB_STRW_MSB 6
`define LSB_PORT_HOLD 6
`define LSB_PORT_SLEEP 7
`define LSB_RESET_BYTE 8'h00
// timing
`define LSB_CLK_NS 5
`define LSB_LATCH_NS 500
`define LSB_LATCH_CYC ((`LSB_LATCH_NS) / (`LSB_CLK_NS))
`define LSB_UNIT_PERIODS 100
`define LSB_RESP_EDGES 5
`define LSB_WORD_BITS 24
`define LSB_SEC_DIV 8
`endif

// ---- src/lsb_pkg.sv ----
package lsb_pkg;
  typedef enum logic [2:0] {
    ST_IDLE, ST_SHIFT, ST_GAP, ST_RECV
  } lsb_state_t;
  typedef enum logic {BUS_SECONDARY, BUS_MAIN} lsb_bus_t;
endpackage : lsb_pkg

// ---- src/lsb_master.sv ----
`timescale 1ns/10ps
`include "lsb_regs.svh"
module lsb_master import lsb_pkg::*; #(
  parameter int WORD_BITS = `LSB_WORD_BITS,
  parameter int LATCH_CYC = `LSB_LATCH_CYC,
  parameter int UNIT_PERIODS = `LSB_UNIT_PERIODS,
  parameter int RESP_EDGES = `LSB_RESP_EDGES
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // main serial bus
  input wire logic bus_clock,
  input wire logic serial_data_line_i,
  output logic serial_data_line_o,
  output logic serial_data_line_oe,
  output logic latch0,
  output logic latch1,
  output logic latch2,
  output logic latch3,
  // secondary bus
  output logic secondary_bus_clock,
  output logic secondary_bus_data,
  // events to the interrupt controller
  output logic send_done_irq,
  output logic receive_done_irq
);
  initial begin
    // three fixed byte registers on each side tie the word to 24 bits
    if (WORD_BITS != 24) $error("WORD_BITS must be 24");
    if (LATCH_CYC < 1 || LATCH_CYC > 255) $error("LATCH_CYC out of range");
    if (UNIT_PERIODS < 1 || UNIT_PERIODS > 255)
      $error("UNIT_PERIODS out of range");
    if (RESP_EDGES < 1 || RESP_EDGES > 15) $error("RESP_EDGES out of range");
  end

  // ----------------------------------------------------------------
  // pin synchronisers and bus clock edge detect
  // ----------------------------------------------------------------
  logic bc_q1_r, bc_q2_r, bc_q3_r, dl_q1_r, dl_q2_r;
  logic bus_fall;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bc_q1_r <= 1'b0;
      bc_q2_r <= 1'b0;
      bc_q3_r <= 1'b0;
      dl_q1_r <= 1'b0;
      dl_q2_r <= 1'b0;
    end else begin
      bc_q1_r <= bus_clock;
      bc_q2_r <= bc_q1_r;
      bc_q3_r <= bc_q2_r;
      dl_q1_r <= serial_data_line_i;
      dl_q2_r <= dl_q1_r;
    end
  end

  // ----------------------------------------------------------------
  // register file and axi4-lite slave
  // ----------------------------------------------------------------
  logic [7:0] tx_r [3];
  logic [7:0] rx_r [3];
  logic [7:0] ctrl_r, strw_r, port_r;
  logic [7:0] aw_addr_r, ar_addr_r;
  logic [7:0] w_byte_r;
  logic aw_got_r, w_got_r, w_lane_r, wr_go, wr_ok;
  logic strw_dec, ctrl_clr, sleep, hold;
  lsb_state_t state_r;
  logic l3_act_r;

  assign awready = !aw_got_r && !bvalid;
  assign wready = !w_got_r && !bvalid;
  assign arready = !rvalid;
  assign wr_go = aw_got_r && w_got_r && !bvalid;
  assign wr_ok = aw_addr_r <= `LSB_OFF_PORT && aw_addr_r[1:0] == 2'b00;
  assign sleep = port_r[`LSB_PORT_SLEEP];
  assign hold = port_r[`LSB_PORT_HOLD];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_byte_r <= 8'h00;
      w_lane_r <= 1'b0;
      bvalid <= 1'b0;
      bresp <= 2'b00;
    end else begin
      if (awvalid && awready) begin
        aw_got_r <= 1'b1;
        aw_addr_r <= awaddr;
      end
      if (wvalid && wready) begin
        w_got_r <= 1'b1;
        w_byte_r <= wdata[7:0];
        w_lane_r <= wstrb[0];
      end
      if (wr_go) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wr_ok ? 2'b00 : 2'b10;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // register writes; hardware decrement loses to software, hardware clear only meets ignored control writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_r <= '{default: `LSB_RESET_BYTE};
      ctrl_r <= `LSB_RESET_BYTE;
      strw_r <= `LSB_RESET_BYTE;
      port_r <= `LSB_RESET_BYTE;
    end else begin
      if (ctrl_clr) ctrl_r <= 8'h00;
      if (strw_dec) strw_r <= strw_r - 8'h01;
      if (wr_go && w_lane_r) begin
        unique case (aw_addr_r)
          `LSB_OFF_TX0: tx_r[0] <= w_byte_r;
          `LSB_OFF_TX1: tx_r[1] <= w_byte_r;
          `LSB_OFF_TX2: tx_r[2] <= w_byte_r;
          // a busy engine ignores new control words
          `LSB_OFF_CTRL: if (state_r == ST_IDLE && ctrl_r == 8'h00)
            ctrl_r <= w_byte_r;
          `LSB_OFF_STRW: strw_r <= {1'b0, w_byte_r[`LSB_STRW_MSB:0]};
          `LSB_OFF_PORT: port_r <= w_byte_r & 8'hc0;
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ar_addr_r <= 8'h00;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= 2'b00;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp <= (araddr <= `LSB_OFF_PORT && araddr[1:0] == 2'b00)
        ? 2'b00 : 2'b10;
      ar_addr_r <= araddr;
      unique case (araddr)
        `LSB_OFF_RX0: rdata <= {24'h000000, rx_r[0]};
        `LSB_OFF_RX1: rdata <= {24'h000000, rx_r[1]};
        `LSB_OFF_RX2: rdata <= {24'h000000, rx_r[2]};
        `LSB_OFF_STAT: rdata <= {30'h0000_0000, l3_act_r,
          state_r != ST_IDLE};
        `LSB_OFF_PORT: rdata <= {24'h000000, port_r};
        default: rdata <= 32'h0000_0000;
      endcase
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // shift engine
  // ----------------------------------------------------------------
  logic [WORD_BITS-1:0] tx_sr_r, rx_sr_r;
  logic [5:0] bit_cnt_r;
  logic [3:0] gap_cnt_r;
  logic [2:0] pre_r;
  logic bus_main_r, ans_r, tick, fire, start, fall_run;
  logic [WORD_BITS-1:0] tx_word;

  // sleep freezes the engine as a stopped clock would
  assign fall_run = bus_fall && !sleep;
  assign bus_fall = bc_q3_r && !bc_q2_r;
  assign start = state_r == ST_IDLE && ctrl_r[`LSB_CTL_GO] && !sleep;
  assign tick = bus_main_r ? fall_run : (fall_run && pre_r == 3'd7);
  assign fire = state_r == ST_SHIFT && tick &&
    bit_cnt_r == 6'(WORD_BITS);
  assign ctrl_clr = fire;
  assign tx_word = WORD_BITS'({tx_r[0], tx_r[1], tx_r[2]});

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= ST_IDLE;
      tx_sr_r <= '0;
      rx_sr_r <= '0;
      bit_cnt_r <= 6'd0;
      gap_cnt_r <= 4'd0;
      bus_main_r <= 1'b1;
      ans_r <= 1'b0;
      serial_data_line_o <= 1'b0;
      serial_data_line_oe <= 1'b0;
      secondary_bus_data <= 1'b0;
    end else begin
      unique case (state_r)
        ST_IDLE: if (start) begin
          state_r <= ST_SHIFT;
          tx_sr_r <= tx_word;
          bit_cnt_r <= 6'd0;
          bus_main_r <= ctrl_r[`LSB_CTL_BUS];
          ans_r <= ctrl_r[`LSB_CTL_ANS] && ctrl_r[`LSB_CTL_BUS];
        end
        ST_SHIFT: if (fire) begin
          serial_data_line_oe <= 1'b0;
          secondary_bus_data <= 1'b0;
          gap_cnt_r <= 4'd0;
          state_r <= ans_r ? ST_GAP : ST_IDLE;
        end else if (tick) begin
          if (bus_main_r) begin
            serial_data_line_o <= tx_sr_r[WORD_BITS-1];
            serial_data_line_oe <= 1'b1;
          end else begin
            secondary_bus_data <= tx_sr_r[WORD_BITS-1];
          end
          tx_sr_r <= tx_sr_r << 1;
          bit_cnt_r <= bit_cnt_r + 6'd1;
        end
        ST_GAP: if (fall_run) begin
          gap_cnt_r <= gap_cnt_r + 4'd1;
          if (gap_cnt_r == 4'(RESP_EDGES - 1)) begin
            rx_sr_r <= {rx_sr_r[WORD_BITS-2:0], dl_q2_r};
            bit_cnt_r <= 6'd1;
            state_r <= ST_RECV;
          end
        end
        ST_RECV: if (bit_cnt_r == 6'(WORD_BITS)) begin
          state_r <= ST_IDLE;
        end else if (fall_run) begin
          rx_sr_r <= {rx_sr_r[WORD_BITS-2:0], dl_q2_r};
          bit_cnt_r <= bit_cnt_r + 6'd1;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // receive bytes and completion pulses
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_r <= '{default: `LSB_RESET_BYTE};
      send_done_irq <= 1'b0;
      receive_done_irq <= 1'b0;
    end else begin
      send_done_irq <= fire;
      receive_done_irq <= 1'b0;
      if (state_r == ST_RECV && bit_cnt_r == 6'(WORD_BITS)) begin
        receive_done_irq <= 1'b1;
        rx_r[0] <= rx_sr_r[23:16];
        rx_r[1] <= rx_sr_r[15:8];
        rx_r[2] <= rx_sr_r[7:0];
      end
    end
  end

  // secondary clock: bus clock / 8, low outside transfers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_r <= 3'd0;
      secondary_bus_clock <= 1'b0;
    end else if (state_r != ST_SHIFT || bus_main_r) begin
      pre_r <= 3'd0;
      secondary_bus_clock <= 1'b0;
    end else if (fall_run && !fire) begin
      pre_r <= pre_r + 3'd1;
      secondary_bus_clock <= (pre_r + 3'd1) >= 3'd4;
    end
  end

  // ----------------------------------------------------------------
  // latch strobes
  // ----------------------------------------------------------------
  logic [7:0] pulse_cnt_r, unit_cnt_r;
  logic [3:0] pulse_sel_r;
  logic main_l3;
  assign main_l3 = bus_main_r && !ctrl_r[`LSB_CTL_L1] &&
    !ctrl_r[`LSB_CTL_L0];
  // one unit of width has elapsed
  assign strw_dec = l3_act_r && strw_r != 8'h00 && fall_run &&
    unit_cnt_r == 8'(UNIT_PERIODS - 1);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pulse_cnt_r <= 8'h00;
      pulse_sel_r <= 4'h0;
    end else if (fire) begin
      pulse_cnt_r <= 8'(LATCH_CYC);
      pulse_sel_r <= bus_main_r
        ? {2'b00, ctrl_r[`LSB_CTL_L1:`LSB_CTL_L0]}
        : {ctrl_r[`LSB_CTL_L3:`LSB_CTL_L2], 2'b00};
    end else if (pulse_cnt_r != 8'h00) begin
      pulse_cnt_r <= pulse_cnt_r - 8'h01;
    end
  end

  // programmed latch 3 runs beside later transfers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      l3_act_r <= 1'b0;
      unit_cnt_r <= 8'h00;
    end else if (fire && main_l3) begin
      l3_act_r <= 1'b1;
      unit_cnt_r <= 8'h00;
    end else if (l3_act_r && strw_r == 8'h00) begin
      l3_act_r <= 1'b0;
    end else if (l3_act_r && fall_run) begin
      unit_cnt_r <= (unit_cnt_r == 8'(UNIT_PERIODS - 1))
        ? 8'h00 : unit_cnt_r + 8'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      latch0 <= 1'b0;
      latch1 <= 1'b0;
      latch2 <= 1'b0;
      latch3 <= 1'b0;
    end else begin
      latch0 <= pulse_cnt_r != 8'h00 && pulse_sel_r[0];
      latch1 <= pulse_cnt_r != 8'h00 && pulse_sel_r[1];
      latch2 <= pulse_cnt_r != 8'h00 && pulse_sel_r[2];
      latch3 <= (pulse_cnt_r != 8'h00 && pulse_sel_r[3]) || hold ||
        (l3_act_r && strw_r != 8'h00);
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_unit_dec;
    @(posedge aclk) disable iff (!aresetn)
      (strw_dec && !(wr_go && w_lane_r && aw_addr_r == `LSB_OFF_STRW))
        |=> strw_r == $past(strw_r) - 8'h01;
  endproperty
  a_unit_dec: assert property (p_unit_dec)
    else $error("width not decremented by one unit");

  property p_zero_ends;
    @(posedge aclk) disable iff (!aresetn)
      (strw_r == 8'h00 && !hold && pulse_cnt_r == 8'h00) |=> !latch3;
  endproperty
  a_zero_ends: assert property (p_zero_ends)
    else $error("latch 3 outlived a zero width");

  property p_sec_fixed;
    @(posedge aclk) disable iff (!aresetn)
      (fire && !bus_main_r && !l3_act_r) |=> !l3_act_r;
  endproperty
  a_sec_fixed: assert property (p_sec_fixed)
    else $error("secondary transfer armed the programmed strobe");

  property p_send_latch;
    @(posedge aclk) disable iff (!aresetn)
      fire |=> send_done_irq ##1 (latch0 || latch1 || latch2 || latch3);
  endproperty
  a_send_latch: assert property (p_send_latch)
    else $error("send done without a latch");

  property p_ctrl_clear;
    @(posedge aclk) disable iff (!aresetn)
      send_done_irq |-> ctrl_r == 8'h00;
  endproperty
  a_ctrl_clear: assert property (p_ctrl_clear)
    else $error("control not cleared at completion");

  property p_gap;
    @(posedge aclk) disable iff (!aresetn)
      (state_r == ST_GAP && fall_run &&
       gap_cnt_r != 4'(RESP_EDGES - 1)) |=> state_r == ST_GAP;
  endproperty
  a_gap: assert property (p_gap)
    else $error("sampling began before the response gap");

  property p_rx_copy;
    @(posedge aclk) disable iff (!aresetn)
      $rose(receive_done_irq) |-> {rx_r[0], rx_r[1], rx_r[2]} ==
        $past(rx_sr_r) && state_r == ST_IDLE;
  endproperty
  a_rx_copy: assert property (p_rx_copy)
    else $error("receive bytes not loaded with the word");

  property p_one_xfer;
    @(posedge aclk) disable iff (!aresetn)
      (state_r != ST_IDLE && ctrl_r == 8'h00) |=> ctrl_r == 8'h00;
  endproperty
  a_one_xfer: assert property (p_one_xfer)
    else $error("control accepted while busy");

  property p_latch_width;
    @(posedge aclk) disable iff (!aresetn)
      $rose(latch0) |-> latch0 [*8];
  endproperty
  a_latch_width: assert property (p_latch_width)
    else $error("latch 0 pulse too short");

  property p_sec_idle;
    @(posedge aclk) disable iff (!aresetn)
      state_r == ST_IDLE |=> !secondary_bus_clock;
  endproperty
  a_sec_idle: assert property (p_sec_idle)
    else $error("secondary clock running while idle");

  property p_hiz;
    @(posedge aclk) disable iff (!aresetn)
      state_r != ST_SHIFT |-> !serial_data_line_oe;
  endproperty
  a_hiz: assert property (p_hiz)
    else $error("data line driven outside shifting");

  property p_hold;
    @(posedge aclk) disable iff (!aresetn) hold |=> latch3;
  endproperty
  a_hold: assert property (p_hold)
    else $error("hold-high did not force latch 3");

  c_main: cover property (@(posedge aclk) fire && bus_main_r);
  c_sec: cover property (@(posedge aclk) fire && !bus_main_r);
  c_recv: cover property (@(posedge aclk) receive_done_irq);
  c_strobe: cover property (@(posedge aclk) strw_dec);
endmodule : lsb_master

// ---- tb/lsb_slave_model.sv ----
`timescale 1ns/10ps
module lsb_slave_model (
  // main bus pins
  input wire logic bus_clock,
  input wire logic line_o,
  input wire logic line_oe,
  input wire logic latch_fire,
  // answer set up by the bench
  input wire logic ans_en,
  input wire logic [23:0] resp_word,
  // observed and driven
  output logic line_i,
  output logic [23:0] got_word
);
  logic drv = 1'b0;
  logic bit_v = 1'b0;
  logic last = 1'b0;
  int falls = 0;
  int idx = 24;
  initial got_word = '0;
  // a released line shows a changing level, never a held stale bit
  assign line_i = line_oe ? line_o : (drv ? bit_v : ~last);
  // master changes on falls, so rises see settled bits
  always @(posedge bus_clock)
    if (line_oe) got_word <= {got_word[22:0], line_o};
  always @(posedge latch_fire) if (ans_en) begin
    falls = 0;
    idx = 0;
  end
  always @(negedge bus_clock) falls = falls + 1;
  // each bit is set up on a rise, ahead of the fall that samples it
  always @(posedge bus_clock) begin
    last <= line_i;
    if (idx < 24 && falls >= 4) begin
      drv <= 1'b1;
      bit_v <= resp_word[23 - idx];
      idx = idx + 1;
    end else
      drv <= 1'b0;
  end
endmodule : lsb_slave_model

// ---- tb/latched_serial_bus_master_tb_top.sv ----
`timescale 1ns/10ps
`include "lsb_regs.svh"
module latched_serial_bus_master_tb_top import lsb_pkg::*;;
  logic aclk = 1'b0, aresetn = 1'b0, bus_clock = 1'b0;
  logic [7:0] awaddr = '0, araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, ans_en = 1'b0;
  logic [31:0] wdata = '0, rdata;
  logic [23:0] resp_word = '0, sec_word = '0, got_word, wd;
  logic [1:0] bresp, rresp;
  logic awready, wready, bvalid, arready, rvalid, line_i, line_o, line_oe;
  logic latch0, latch1, latch2, latch3, sclk, sdat, sdone, rdone;
  logic [7:0] codes [4] = '{8'hc1, 8'hc2, 8'h84, 8'h88};
  int miscompares = 0, n_compared = 0, cyc = 0, w, hits;
  wire [5:0] ev = {rdone, sdone, latch3, latch2, latch1, latch0};

  always #2.5 aclk = ~aclk;
  // link clock free-running, phase unrelated to aclk
  initial begin
    #13.3;
    forever #80 bus_clock = ~bus_clock;
  end
  always @(posedge sclk) sec_word <= {sec_word[22:0], sdat};

  lsb_master #(.UNIT_PERIODS(2)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(1'b1),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(1'b1), .bus_clock(bus_clock),
    .serial_data_line_i(line_i), .serial_data_line_o(line_o),
    .serial_data_line_oe(line_oe), .latch0(latch0), .latch1(latch1),
    .latch2(latch2), .latch3(latch3), .secondary_bus_clock(sclk),
    .secondary_bus_data(sdat), .send_done_irq(sdone),
    .receive_done_irq(rdone));
  lsb_slave_model u_slave (
    .bus_clock(bus_clock), .line_o(line_o), .line_oe(line_oe),
    .latch_fire(latch0 | latch1), .ans_en(ans_en), .resp_word(resp_word),
    .line_i(line_i), .got_word(got_word));

  // ----------------------------------------
  // bus tasks and checks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, exp, input string m);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %0t %s seen %h exp %h", $time, m, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, d, input logic [1:0] er);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    chk(32'(bresp), 32'(er), "bresp");
  endtask : wr
  task automatic rd(input logic [7:0] a, ed, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    chk(rdata, {24'h0, ed}, "rdata");
    chk(32'(rresp), 32'(er), "rresp");
  endtask : rd
  task automatic wait_ev(input int k, lim);
    int n;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (ev[k] !== 1'b1 && n < lim);
    chk(32'(ev[k]), 32'h1, "event");
  endtask : wait_ev
  task automatic width(input int k, output int wc);
    wait_ev(k, 20);
    wc = 0;
    while (ev[k] === 1'b1 && wc < 9000) begin
      wc++;
      @(posedge aclk);
    end
  endtask : width
  task automatic xfer(input logic [23:0] x, input logic [7:0] c);
    wr(`LSB_OFF_TX0, x[23:16], 2'b00);
    wr(`LSB_OFF_TX1, x[15:8], 2'b00);
    wr(`LSB_OFF_TX2, x[7:0], 2'b00);
    wr(`LSB_OFF_CTRL, c, 2'b00);
  endtask : xfer
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : wrap_up

  // cuts a hang short
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      miscompares++;
      wrap_up();
    end
  end

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`LSB_OFF_PORT, 8'h00, 2'b00);
    rd(`LSB_OFF_CTRL, 8'h00, 2'b00);
    rd(8'h28, 8'h00, 2'b10);
    wr(8'h2c, 8'h11, 2'b10);
    wr(`LSB_OFF_RX0, 8'hff, 2'b00);
    rd(`LSB_OFF_RX0, 8'h00, 2'b00);
    // width stays zero here; the fixed-width latches do not use it
    for (int i = 0; i < 4; i++) begin
      wd = 24'ha53c81 + 24'(i * 24'h111111);
      xfer(wd, codes[i]);
      if (i == 0) wr(`LSB_OFF_CTRL, 8'hc2, 2'b00);
      wait_ev(4, 8000);
      width(i, w);
      chk(32'(w), 32'd100, "latch width");
      if (i < 2) chk({8'h0, got_word}, {8'h0, wd}, "main word");
      else chk({8'h0, sec_word}, {8'h0, wd}, "sec word");
      chk(32'(sclk), 32'h0, "sec clk idle");
      rd(`LSB_OFF_STAT, 8'h00, 2'b00);
    end
    ans_en <= 1'b1;
    resp_word <= 24'h5a0ff1;
    xfer(24'h123456, 8'he2);
    rd(`LSB_OFF_STAT, 8'h01, 2'b00);
    wait_ev(4, 2000);
    width(1, w);
    chk(32'(w), 32'd100, "answer latch");
    wait_ev(5, 2000);
    chk(32'(line_oe), 32'h0, "line released");
    ans_en <= 1'b0;
    rd(`LSB_OFF_RX0, 8'h5a, 2'b00);
    rd(`LSB_OFF_RX1, 8'h0f, 2'b00);
    rd(`LSB_OFF_RX2, 8'hf1, 2'b00);
    wr(`LSB_OFF_STRW, 8'h03, 2'b00);
    xfer(24'h00ff00, 8'hc0);
    wait_ev(4, 2000);
    width(3, w);
    chk(32'(w >= 180 && w <= 200), 32'h1, "strobe time");
    wr(`LSB_OFF_STRW, 8'h64, 2'b00);
    xfer(24'h0f0f0f, 8'hc0);
    wait_ev(4, 2000);
    xfer(24'h777777, 8'hc1);
    wait_ev(4, 2000);
    chk(32'(latch3), 32'h1, "latch3 held");
    rd(`LSB_OFF_STAT, 8'h02, 2'b00);
    wr(`LSB_OFF_STRW, 8'h00, 2'b00);
    repeat (3) @(posedge aclk);
    chk(32'(latch3), 32'h0, "latch3 ended");
    wr(`LSB_OFF_PORT, 8'h40, 2'b00);
    rd(`LSB_OFF_PORT, 8'h40, 2'b00);
    chk(32'(latch3), 32'h1, "hold high");
    wr(`LSB_OFF_PORT, 8'h80, 2'b00);
    // latch 3 is registered one cycle behind the port write
    repeat (2) @(posedge aclk);
    chk(32'(latch3), 32'h0, "hold off");
    xfer(24'h3c3c3c, 8'hc1);
    hits = 0;
    repeat (1000) begin
      @(posedge aclk);
      if (sdone === 1'b1) hits++;
    end
    chk(32'(hits), 32'h0, "sleep");
    wr(`LSB_OFF_PORT, 8'h00, 2'b00);
    wait_ev(4, 2000);
    wrap_up();
  end
endmodule : latched_serial_bus_master_tb_top
